/* logic/sfp_pkg.sv */
package sfp_pkg;
    localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] OP_QUAD_PROGRAM  = 8'h32;
    localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam int PAGE_BYTES   = 256;
    localparam int ADDR_W       = 24;
    localparam int SECTOR_LSB   = 12;
    localparam int BLOCK32_LSB  = 15;
    localparam int BLOCK64_LSB  = 16;
    localparam int CLK_MHZ      = 250;
    localparam int PROGRAM_US   = 1;
    localparam int SECTOR_US    = 2;
    localparam int BLOCK_US     = 4;
    localparam int PROGRAM_CYC  = PROGRAM_US * CLK_MHZ;
    localparam int SECTOR_CYC   = SECTOR_US * CLK_MHZ;
    localparam int BLOCK_CYC    = BLOCK_US * CLK_MHZ;
    localparam int TIMER_W      = 32;
    typedef enum logic [4:0] {
        SFP_IDLE   = 5'b00001,
        SFP_CMD    = 5'b00010,
        SFP_ADDR   = 5'b00100,
        SFP_DATA   = 5'b01000,
        SFP_BUSY   = 5'b10000
    } sfp_state_t;
    typedef enum logic [1:0] {
        SFP_OP_PROG = 2'h0,
        SFP_OP_SECT = 2'h1,
        SFP_OP_B32  = 2'h2,
        SFP_OP_B64  = 2'h3
    } sfp_op_t;
endpackage

/* logic/sfp_program_erase.sv */
// Behaviour
// RULE_01 - Host sends write enable before any program or erase.
// RULE_02 - Page program: opcode 02H, three address bytes, data bytes, chip select high.
// RULE_03 - Host holds chip select low for the whole command.
// RULE_04 - Program address wraps inside the current 256-byte page.
// RULE_05 - Over 256 bytes: only the last 256 are programmed.
// RULE_06 - Short data programs only addressed bytes, others untouched.
// RULE_07 - Program runs only if select rises on a byte boundary.
// RULE_08 - Select rise starts timed program cycle; busy flag high meanwhile.
// RULE_09 - Write enable latch is cleared before the internal cycle ends.
// RULE_10 - Program to a protected page is refused.
// RULE_11 - Quad program 32H uses four lines, only with quad enable set.
// RULE_12 - Host sends quad opcode, address, then data on four lines.
// RULE_13 - Quad program has the same timed cycle as page program.
// RULE_14 - Sector erase 20H erases the sector holding the address.
// RULE_15 - Erase runs only if select rises right after third address byte.
// RULE_16 - Sector erase starts a timed cycle; busy flag high until done.
// RULE_17 - Sector erase of a protected sector is refused.
// RULE_18 - Opcode 52H erases the 32KB block holding the address.
// RULE_19 - Opcode D8H erases the 64KB block holding the address.
// RULE_20 - Block erase starts a timed cycle; busy flag high meanwhile.
// RULE_21 - Block erase of a protected block is refused.
// RULE_22 - Without write enable latch the command is ignored, busy stays low.
`timescale 1ns/10ps
`default_nettype none
module sfp_program_erase
    import sfp_pkg::*;
(
    input  wire logic        clk,             // System clock.
    input  wire logic        sys_rst,         // Synchronous reset, active high.
    input  wire logic        spi_cs_n,        // Chip select pin, active low.
    input  wire logic        spi_sclk,        // Serial clock pin.
    input  wire logic [3:0]  spi_io,          // Data pins; bit 0 is serial input.
    input  wire logic        quad_enable,     // Quad enable status bit.
    input  wire logic [4:0]  block_protect,   // Block protect bits, bit 4 down to bit 0.
    input  wire logic [ADDR_W-1:0] protect_base,  // Lowest protected byte address.
    output logic             write_in_progress,   // Internal cycle busy.
    output logic             write_enable_latch,  // Write enable latch state.
    output logic             mem_we,          // Page buffer byte write strobe to array.
    output logic [ADDR_W-1:0] mem_addr,       // Array byte address or erase base.
    output logic [7:0]       mem_wdata,       // Byte to program.
    output logic             erase_start,     // One-cycle erase request.
    output logic [1:0]       erase_kind       // Region of the erase request.
);
    // Pin synchronisers: three flops; chip select and clock change only when stages two and three agree, data lines pass through.
    logic [2:0] cs_sync_reg, sclk_sync_reg;
    logic [3:0] io_s1_reg, io_s2_reg;
    logic       cs_n_reg, sclk_reg;
    logic [3:0] io_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_sync_reg   <= 3'h7;
            sclk_sync_reg <= 3'h0;
            io_s1_reg     <= 4'h0;
            io_s2_reg     <= 4'h0;
            io_reg        <= 4'h0;
            cs_n_reg      <= 1'b1;
            sclk_reg      <= 1'b0;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
            sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
            io_s1_reg     <= spi_io;
            io_s2_reg     <= io_s1_reg;
            io_reg        <= io_s2_reg;
            if (cs_sync_reg[1] == cs_sync_reg[2])
                cs_n_reg <= cs_sync_reg[2];
            if (sclk_sync_reg[1] == sclk_sync_reg[2])
                sclk_reg <= sclk_sync_reg[2];
        end
    end
    logic sclk_prev_reg, cs_prev_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_reg;
            cs_prev_reg   <= cs_n_reg;
        end
    end
    wire sclk_rise = sclk_reg & ~sclk_prev_reg & ~cs_n_reg;
    wire cs_rise   = cs_n_reg & ~cs_prev_reg;
    wire cs_fall   = ~cs_n_reg & cs_prev_reg;

    sfp_state_t state_reg, state_next;
    sfp_op_t    op_reg;
    logic       quad_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] addr_cnt_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [8:0] data_cnt_reg;
    logic [7:0] page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_valid_reg;
    logic [7:0] wr_off_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic [8:0] flush_idx_reg;
    logic       flushing_reg;

    // Quad data moves four bits per clock; opcode and address stay serial.
    wire       quad_phase = quad_reg & (state_reg == SFP_DATA);
    wire [7:0] shift_in   = quad_phase ? {shift_reg[3:0], io_reg} : {shift_reg[6:0], io_reg[0]};
    wire [2:0] bit_step   = quad_phase ? 3'h4 : 3'h1;
    wire       byte_done  = sclk_rise & ((bit_cnt_reg + bit_step) == 3'h0);
    wire       on_boundary = (bit_cnt_reg == 3'h0);

    // Protection region is the top of the array above protect_base when any bit is set.
    wire protect_on = |block_protect;
    wire [ADDR_W-1:0] region_lo =
        (op_reg == SFP_OP_PROG) ? {addr_reg[ADDR_W-1:8], 8'h00} :
        (op_reg == SFP_OP_SECT) ? {addr_reg[ADDR_W-1:SECTOR_LSB], 12'h000} :
        (op_reg == SFP_OP_B32)  ? {addr_reg[ADDR_W-1:BLOCK32_LSB], 15'h0000} :
                                  {addr_reg[ADDR_W-1:BLOCK64_LSB], 16'h0000};
    wire [ADDR_W-1:0] region_hi =
        (op_reg == SFP_OP_PROG) ? {addr_reg[ADDR_W-1:8], 8'hFF} :
        (op_reg == SFP_OP_SECT) ? {addr_reg[ADDR_W-1:SECTOR_LSB], 12'hFFF} :
        (op_reg == SFP_OP_B32)  ? {addr_reg[ADDR_W-1:BLOCK32_LSB], 15'h7FFF} :
                                  {addr_reg[ADDR_W-1:BLOCK64_LSB], 16'hFFFF};
    wire region_locked = protect_on & (region_hi >= protect_base); // RULE_10 RULE_17 RULE_21
    wire is_prog       = (op_reg == SFP_OP_PROG);
    wire prog_ok  = is_prog & (state_reg == SFP_DATA) & on_boundary & (data_cnt_reg != 9'h0); // RULE_07
    wire erase_ok = ~is_prog & (state_reg == SFP_DATA) & on_boundary & (data_cnt_reg == 9'h0); // RULE_15
    wire accept   = cs_rise & (prog_ok | erase_ok) & write_enable_latch & ~region_locked; // RULE_22
    wire [TIMER_W-1:0] cycle_len =
        is_prog ? TIMER_W'(PROGRAM_CYC) : // RULE_08 RULE_13
        (op_reg == SFP_OP_SECT) ? TIMER_W'(SECTOR_CYC) : TIMER_W'(BLOCK_CYC); // RULE_16 RULE_20
    wire [7:0] opcode = shift_in;
    wire op_known = (opcode == OP_PAGE_PROGRAM) | (opcode == OP_SECTOR_ERASE) |
                    (opcode == OP_BLOCK32_ERASE) | (opcode == OP_BLOCK64_ERASE) |
                    ((opcode == OP_QUAD_PROGRAM) & quad_enable); // RULE_11
    wire write_enable_cmd_seen = (state_reg == SFP_CMD) & byte_done & (opcode == OP_WRITE_ENABLE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SFP_IDLE: if (cs_fall) state_next = SFP_CMD;
            SFP_CMD: begin
                if (cs_n_reg)
                    state_next = SFP_IDLE;
                else if (byte_done)
                    state_next = op_known ? SFP_ADDR : SFP_IDLE;
            end
            SFP_ADDR: begin
                if (cs_n_reg)
                    state_next = SFP_IDLE;
                else if (byte_done && addr_cnt_reg == 2'h2)
                    state_next = SFP_DATA;
            end
            SFP_DATA: if (cs_rise) state_next = accept ? SFP_BUSY : SFP_IDLE;
            SFP_BUSY: if (timer_reg == '0 && !flushing_reg) state_next = SFP_IDLE;
            default: state_next = SFP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg    <= SFP_IDLE;
            op_reg       <= SFP_OP_PROG;
            quad_reg     <= 1'b0;
            shift_reg    <= 8'h00;
            bit_cnt_reg  <= 3'h0;
            addr_cnt_reg <= 2'h0;
            addr_reg     <= '0;
            data_cnt_reg <= 9'h0;
            wr_off_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (cs_fall) begin
                bit_cnt_reg  <= 3'h0;
                addr_cnt_reg <= 2'h0;
                data_cnt_reg <= 9'h0;
            end else if (sclk_rise) begin
                shift_reg   <= shift_in;
                bit_cnt_reg <= bit_cnt_reg + bit_step;
            end
            if (state_reg == SFP_CMD && byte_done) begin
                quad_reg <= (opcode == OP_QUAD_PROGRAM);
                op_reg   <= (opcode == OP_SECTOR_ERASE)  ? SFP_OP_SECT :
                            (opcode == OP_BLOCK32_ERASE) ? SFP_OP_B32 :
                            (opcode == OP_BLOCK64_ERASE) ? SFP_OP_B64 : SFP_OP_PROG;
            end
            if (state_reg == SFP_ADDR && byte_done) begin
                addr_reg     <= {addr_reg[15:0], shift_in};
                addr_cnt_reg <= addr_cnt_reg + 2'h1;
                wr_off_reg   <= shift_in;
            end
            if (state_reg == SFP_DATA && byte_done) begin
                wr_off_reg <= wr_off_reg + 8'h01; // RULE_04
                if (data_cnt_reg != 9'h1FF)
                    data_cnt_reg <= data_cnt_reg + 9'h001;
            end
        end
    end

    // Each offset keeps only its latest byte, so a long stream leaves the last 256.
    always_ff @(posedge clk) begin
        if (state_reg == SFP_DATA && byte_done && is_prog)
            page_buf[wr_off_reg] <= shift_in; // RULE_05
    end
    always_ff @(posedge clk) begin
        if (sys_rst || cs_fall)
            page_valid_reg <= '0;
        else if (state_reg == SFP_DATA && byte_done && is_prog)
            page_valid_reg[wr_off_reg] <= 1'b1; // RULE_06
    end

    // Busy timer, write enable latch and array strobes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_reg          <= '0;
            write_in_progress  <= 1'b0;
            write_enable_latch <= 1'b0;
            flushing_reg       <= 1'b0;
            flush_idx_reg      <= 9'h0;
            mem_we             <= 1'b0;
            mem_addr           <= '0;
            mem_wdata          <= 8'h00;
            erase_start        <= 1'b0;
            erase_kind         <= 2'h0;
        end else begin
            mem_we      <= 1'b0;
            erase_start <= 1'b0;
            if (write_enable_cmd_seen && state_reg != SFP_BUSY)
                write_enable_latch <= 1'b1;
            if (accept) begin
                timer_reg         <= cycle_len;
                write_in_progress <= 1'b1; // RULE_08 RULE_16 RULE_20
                flushing_reg      <= is_prog;
                flush_idx_reg     <= 9'h0;
                erase_start       <= ~is_prog; // RULE_14 RULE_18 RULE_19
                erase_kind        <= op_reg;
                mem_addr          <= region_lo;
            end else if (state_reg == SFP_BUSY) begin
                if (timer_reg != '0)
                    timer_reg <= timer_reg - TIMER_W'(1);
                if (timer_reg == TIMER_W'(1))
                    write_enable_latch <= 1'b0; // RULE_09
                if (flushing_reg) begin
                    // Only bytes that arrived are written; the rest of the page is left alone.
                    mem_we    <= page_valid_reg[flush_idx_reg[7:0]]; // RULE_06
                    mem_addr  <= {addr_reg[ADDR_W-1:8], flush_idx_reg[7:0]};
                    mem_wdata <= page_buf[flush_idx_reg[7:0]];
                    flush_idx_reg <= flush_idx_reg + 9'h001;
                    if (flush_idx_reg == 9'h0FF)
                        flushing_reg <= 1'b0;
                end
                if (timer_reg == '0 && !flushing_reg) begin
                    write_in_progress  <= 1'b0;
                    write_enable_latch <= 1'b0;
                end
            end
        end
    end

    property p_busy_on_accept;
        @(posedge clk) disable iff (sys_rst)
        accept |=> write_in_progress;
    endproperty
    a_busy_on_accept: assert property (p_busy_on_accept) // RULE_08
        else $error("busy flag not raised after accepted command");

    property p_no_wel_no_busy;
        @(posedge clk) disable iff (sys_rst)
        (cs_rise && !write_enable_latch && !write_in_progress) |=> !write_in_progress;
    endproperty
    a_no_wel_no_busy: assert property (p_no_wel_no_busy) // RULE_22
        else $error("command ran without write enable latch");

    property p_locked_refused;
        @(posedge clk) disable iff (sys_rst)
        (cs_rise && region_locked && !write_in_progress) |=> !write_in_progress;
    endproperty
    a_locked_refused: assert property (p_locked_refused) // RULE_10
        else $error("protected region was modified");

    property p_wel_cleared;
        @(posedge clk) disable iff (sys_rst)
        $fell(write_in_progress) |-> !write_enable_latch;
    endproperty
    a_wel_cleared: assert property (p_wel_cleared) // RULE_09
        else $error("write enable latch still set after cycle");

    property p_erase_boundary;
        @(posedge clk) disable iff (sys_rst)
        (cs_rise && !is_prog && data_cnt_reg != 9'h0) |=> !erase_start;
    endproperty
    a_erase_boundary: assert property (p_erase_boundary) // RULE_15
        else $error("erase accepted with extra clocks");

    property p_prog_partial;
        @(posedge clk) disable iff (sys_rst)
        (cs_rise && is_prog && !on_boundary && !write_in_progress) |=> !write_in_progress;
    endproperty
    a_prog_partial: assert property (p_prog_partial) // RULE_07
        else $error("program accepted on partial byte");

    property p_erase_pulse;
        @(posedge clk) disable iff (sys_rst)
        erase_start |-> write_in_progress ##1 !erase_start;
    endproperty
    a_erase_pulse: assert property (p_erase_pulse) // RULE_16
        else $error("erase start without busy or too long");

    property p_quad_gate;
        @(posedge clk) disable iff (sys_rst)
        (state_reg == SFP_CMD && byte_done && opcode == OP_QUAD_PROGRAM && !quad_enable)
            |=> state_reg == SFP_IDLE;
    endproperty
    a_quad_gate: assert property (p_quad_gate) // RULE_11
        else $error("quad program taken with quad enable clear");
endmodule
`default_nettype wire

/* test/sfp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sfp_host_model (
    input  wire logic       clk,   // Bench clock.
    output logic            cs_n,  // Chip select, active low.
    output logic            sclk,  // Serial clock, still outside frames.
    output logic [3:0]      io     // Data lines.
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io   = 4'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic begin_f();
        tick(1);
        cs_n = 1'b0;
        tick(4);
    endtask
    // Each sclk phase lasts four clk cycles, above the two the pin filter needs.
    // Unused lines carry a toggling pattern so no stale value can look valid.
    task automatic put(input logic [7:0] v, input int n, input bit quad);
        for (int i = 0; i < n; i++) begin
            io = quad ? v[7-4*i -: 4] : {~io[3:1], v[7-i]};
            tick(4);
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
    endtask
    task automatic end_f();
        tick(4);
        cs_n = 1'b1;
        io   = ~io;
        tick(4);
    endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sfp_pkg::*;
    logic clk, sys_rst, spi_cs_n, spi_sclk, quad_enable, mem_we, erase_start;
    logic write_in_progress, write_enable_latch;
    logic [3:0] spi_io;
    logic [4:0] block_protect;
    logic [ADDR_W-1:0] protect_base, mem_addr, er_addr;
    logic [7:0] mem_wdata;
    logic [1:0] erase_kind, er_kind;
    logic [7:0] mem [logic [ADDR_W-1:0]];
    int failures, cmp_count, we_cnt, er_cnt, len;
    sfp_host_model host_u (.clk(clk), .cs_n(spi_cs_n), .sclk(spi_sclk), .io(spi_io));
    sfp_program_erase dut_u (.clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_io(spi_io), .quad_enable(quad_enable),
        .block_protect(block_protect), .protect_base(protect_base),
        .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .erase_start(erase_start),
        .erase_kind(erase_kind));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] = mem_wdata;
            we_cnt++;
        end
        if (erase_start === 1'b1) begin
            er_addr = mem_addr;
            er_kind = erase_kind;
            er_cnt++;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    function automatic logic [7:0] dat(input int i);
        // The upper bits fold in so a byte sent 256 places later differs from the first one.
        return 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
    endfunction
    task automatic clr();
        we_cnt = 0;
        er_cnt = 0;
        mem.delete();
    endtask
    task automatic write_enable_cmd();
        host_u.begin_f();
        host_u.put(OP_WRITE_ENABLE, 8, 1'b0);
        host_u.end_f();
        host_u.tick(8);
        check(write_enable_latch, 1);
    endtask
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nd,
                         input int extra, input bit quad);
        host_u.begin_f();
        host_u.put(op, 8, 1'b0);
        for (int k = 0; k < 3; k++) host_u.put(a[23-8*k -: 8], 8, 1'b0);
        for (int i = 0; i < nd; i++) host_u.put(dat(i), quad ? 2 : 8, quad);
        if (extra > 0) host_u.put(8'hA5, extra, 1'b0);
        host_u.end_f();
    endtask
    // Measures how long the busy flag stays up; zero means the command never ran.
    task automatic settle();
        len = 0;
        for (int i = 0; i < 20 && write_in_progress !== 1'b1; i++) host_u.tick(1);
        while (write_in_progress === 1'b1 && len < 3000) begin
            host_u.tick(1);
            len++;
        end
        if (len >= 3000) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic t_no_latch();
        clr();
        frame(OP_PAGE_PROGRAM, 24'h000010, 1, 0, 1'b0);
        settle();
        check(len, 0);
        check(we_cnt, 0);
        $display("test no_latch done");
    endtask
    task automatic t_wrap();
        clr();
        write_enable_cmd();
        frame(OP_PAGE_PROGRAM, 24'h0001FE, 3, 0, 1'b0);
        settle();
        check(len >= PROGRAM_CYC, 1);
        check(write_enable_latch, 0);
        check(we_cnt, 3);
        check(mem[24'h0001FE], dat(0));
        check(mem[24'h0001FF], dat(1));
        check(mem[24'h000100], dat(2));
        $display("test wrap done");
    endtask
    task automatic t_quad();
        clr();
        quad_enable = 1'b1;
        write_enable_cmd();
        frame(OP_QUAD_PROGRAM, 24'h000200, 258, 0, 1'b1);
        settle();
        check(len >= PROGRAM_CYC, 1);
        check(we_cnt, 256);
        for (int k = 0; k < 256; k++)
            check(mem[24'h000200 | 24'(k)], dat(k < 2 ? k + 256 : k));
        quad_enable = 1'b0;
        write_enable_cmd();
        frame(OP_QUAD_PROGRAM, 24'h000300, 2, 0, 1'b1);
        settle();
        check(len, 0);
        $display("test quad done");
    endtask
    task automatic t_cut();
        clr();
        write_enable_cmd();
        frame(OP_PAGE_PROGRAM, 24'h000400, 1, 3, 1'b0);
        settle();
        check(len, 0);
        check(we_cnt, 0);
        frame(OP_SECTOR_ERASE, 24'h001000, 0, 4, 1'b0);
        settle();
        check(len, 0);
        frame(OP_SECTOR_ERASE, 24'h001000, 1, 0, 1'b0);
        settle();
        check(len, 0);
        check(er_cnt, 0);
        $display("test cut done");
    endtask
    task automatic t_erase();
        logic [7:0] ops [3] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
        int lsb [3] = '{SECTOR_LSB, BLOCK32_LSB, BLOCK64_LSB};
        int cyc [3] = '{SECTOR_CYC, BLOCK_CYC, BLOCK_CYC};
        logic [23:0] a;
        a = 24'h0A5A5A;
        for (int i = 0; i < 3; i++) begin
            clr();
            write_enable_cmd();
            frame(ops[i], a, 0, 0, 1'b0);
            settle();
            check(len, cyc[i] + 1);
            check(er_cnt, 1);
            check(er_kind, i + 1);
            check(er_addr, (a >> lsb[i]) << lsb[i]);
            check(write_enable_latch, 0);
        end
        $display("test erase done");
    endtask
    task automatic t_protect();
        logic [7:0] ops [4] = '{OP_BLOCK64_ERASE, OP_SECTOR_ERASE, OP_PAGE_PROGRAM,
                                OP_SECTOR_ERASE};
        logic [23:0] adr [4] = '{24'h0A0000, 24'h0A1000, 24'h0A0000, 24'h010000};
        int exp [4] = '{0, 0, 0, SECTOR_CYC + 1};
        clr();
        block_protect = 5'h01;
        protect_base = 24'h080000;
        for (int i = 0; i < 4; i++) begin
            write_enable_cmd();
            frame(ops[i], adr[i], i == 2 ? 1 : 0, 0, 1'b0);
            settle();
            check(len, exp[i]);
        end
        check(we_cnt, 0);
        $display("test protect done");
    endtask
    initial begin
        failures = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        quad_enable = 1'b0;
        block_protect = 5'h00;
        protect_base = 24'hFFFFFF;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        host_u.tick(2);
        t_no_latch();
        t_wrap();
        t_quad();
        t_cut();
        t_erase();
        t_protect();
        give_verdict();
    end
endmodule
`default_nettype wire
